// ===== pkg/nfh_pkg.sv
// Constants for the NAND erase, ID and status host controller
`default_nettype none
package nfh_pkg;
	// Clock and pin timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_WP_NS       = 12;
	localparam int T_WH_NS       = 10;
	localparam int T_REA_NS      = 20;
	localparam int T_WB_NS       = 100;
	localparam int SYNC_STAGES   = 2;
	localparam logic [3:0] WP_CYC =
		4'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WH_CYC =
		4'((T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] RD_LO_CYC =
		4'((T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
	localparam logic [3:0] WB_CYC =
		4'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Device commands
	localparam logic [7:0] C_ERASE_SETUP = 8'h60;
	localparam logic [7:0] C_ERASE_START = 8'hD0;
	localparam logic [7:0] C_STATUS      = 8'h70;
	localparam logic [7:0] C_STATUS_DIST = 8'h71;
	localparam logic [7:0] C_ID_READ     = 8'h90;
	localparam logic [7:0] C_RESET       = 8'hFF;
	localparam logic [7:0] ID_ADDR       = 8'h00;
	// Operations software may start
	localparam logic [2:0] OP_ERASE1 = 3'h0;
	localparam logic [2:0] OP_ERASE2 = 3'h1;
	localparam logic [2:0] OP_ID     = 3'h2;
	localparam logic [2:0] OP_ST70   = 3'h3;
	localparam logic [2:0] OP_ST71   = 3'h4;
	localparam logic [2:0] OP_RESET  = 3'h5;
	// Sequencer step kinds
	localparam logic [2:0] K_CMD  = 3'h0;
	localparam logic [2:0] K_ADDR = 3'h1;
	localparam logic [2:0] K_READ = 3'h2;
	localparam logic [2:0] K_WAIT = 3'h3;
	localparam logic [2:0] K_END  = 3'h4;
	// Block addressing
	localparam int BLK_W      = 12;
	localparam int PAGE_W     = 6;
	localparam int ROW_W      = 24;
	localparam int DIST_BIT   = 0;
	localparam int HALF_BIT   = 11;
	localparam int ID_BYTES   = 5;
	// Software register map
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_BLK_A  = 8'h04;
	localparam logic [7:0] REG_BLK_B  = 8'h08;
	localparam logic [7:0] REG_CTRL   = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_ID_LO  = 8'h14;
	localparam logic [7:0] REG_ID_HI  = 8'h18;
	localparam int CMD_START_BIT = 3;
	localparam logic WP_PERMIT_RST = 1'b0;
endpackage
`default_nettype wire

// ===== rtl/nfh_host.sv
// Host controller driving NAND erase, ID read, status and reset
// Functional notes
// - Copy pages share in-block page number
// - Restart copy when block address changes
// - Erase is 60h, block address, D0h
// - Dual erase: two 60h addresses, D0h, 71h
// - Both dual blocks in same array half
// - At most one block per district
// - Dual erase ends with D0h or FFh
// - 70h makes status appear per read strobe
// - Pass/fail valid after program/erase when ready
// - Busy device accepts only 70h, 71h, FFh
`default_nettype none
module nfh_host (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       clk_en_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic     [31:0] rdata_o,
	input  wire logic [7:0] io_i,
	output logic      [7:0] io_o,
	output logic            io_oe_o,
	output logic            cle_o,
	output logic            ale_o,
	output logic            ce_n_o,
	output logic            we_n_o,
	output logic            read_strobe_n_o,
	output logic            wp_n_o,
	input  wire logic       ready_n_busy_i
);
	import nfh_pkg::*;
	typedef enum logic [2:0] {
		S_IDLE, S_FETCH, S_WLO, S_WHI, S_RLO, S_RHI, S_WB, S_WRDY
	} nfh_state_e;
	// Pick one row-address byte
	function automatic logic [7:0] byte_f(input logic [ROW_W-1:0] r,
		input logic [1:0] n);
		byte_f = r[{n, 3'b000} +: 8];
	endfunction
	// Step table: what each operation puts on the pins
	function automatic logic [10:0] step_f(input logic [2:0] op,
		input logic [3:0] i, input logic [ROW_W-1:0] ra,
		input logic [ROW_W-1:0] rb);
		logic [10:0] s;
		s = {K_END, 8'h00};
		case (op)
			OP_ERASE1: begin
				case (i)
					4'h0: s = {K_CMD, C_ERASE_SETUP};
					4'h1, 4'h2, 4'h3: s = {K_ADDR, byte_f(ra, 2'(i - 4'h1))};
					4'h4: s = {K_CMD, C_ERASE_START};
					4'h5: s = {K_WAIT, 8'h00};
					4'h6: s = {K_CMD, C_STATUS};
					4'h7: s = {K_READ, 8'h00};
					default: s = {K_END, 8'h00};
				endcase
			end
			OP_ERASE2: begin
				case (i)
					4'h0, 4'h4: s = {K_CMD, C_ERASE_SETUP};
					4'h1, 4'h2, 4'h3: s = {K_ADDR, byte_f(ra, 2'(i - 4'h1))};
					4'h5, 4'h6, 4'h7: s = {K_ADDR, byte_f(rb, 2'(i - 4'h5))};
					4'h8: s = {K_CMD, C_ERASE_START};
					4'h9: s = {K_WAIT, 8'h00};
					4'hA: s = {K_CMD, C_STATUS_DIST};
					4'hB: s = {K_READ, 8'h00};
					default: s = {K_END, 8'h00};
				endcase
			end
			OP_ID: begin
				case (i)
					4'h0: s = {K_CMD, C_ID_READ};
					4'h1: s = {K_ADDR, ID_ADDR};
					4'h2, 4'h3, 4'h4, 4'h5, 4'h6: s = {K_READ, 8'h00};
					default: s = {K_END, 8'h00};
				endcase
			end
			OP_ST70, OP_ST71: begin
				if (i == 4'h0)
					s = {K_CMD, (op == OP_ST70) ? C_STATUS
						: C_STATUS_DIST};
				else if (i == 4'h1)
					s = {K_READ, 8'h00};
			end
			OP_RESET: begin
				if (i == 4'h0)
					s = {K_CMD, C_RESET};
				else if (i == 4'h1)
					s = {K_WAIT, 8'h00};
			end
			default: s = {K_END, 8'h00};
		endcase
		return s;
	endfunction
	nfh_state_e       state_q;
	logic [2:0]       op_q;
	logic [3:0]       idx_q;
	logic [3:0]       cnt_q;
	logic [2:0]       rd_cnt_q;
	logic [BLK_W-1:0] blk_a_q;
	logic [BLK_W-1:0] blk_b_q;
	logic             wp_permit_q;
	logic             refused_q;
	logic             pf_valid_q;
	logic [7:0]       status_q;
	logic [7:0]       id_q [ID_BYTES];
	logic [7:0]       io_s1_q;
	logic [7:0]       io_s2_q;
	logic             rb_s1_q;
	logic             rb_s2_q;
	// Input synchronisers, two stages each
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			{io_s1_q, io_s2_q, rb_s1_q, rb_s2_q} <= '0;
		end else if (clk_en_i) begin
			{io_s2_q, io_s1_q} <= {io_s1_q, io_i};
			{rb_s2_q, rb_s1_q} <= {rb_s1_q, ready_n_busy_i};
		end
	end
	// Command acceptance and checks
	wire [2:0] req_op   = wdata_i[2:0];
	wire       cmd_wr   = wr_i && (addr_i == REG_CMD) && wdata_i[CMD_START_BIT];
	wire       dist_ok  = blk_a_q[DIST_BIT] != blk_b_q[DIST_BIT];
	wire       half_ok  = blk_a_q[HALF_BIT] == blk_b_q[HALF_BIT];
	wire       busy_ok  = rb_s2_q || req_op == OP_ST70
		|| req_op == OP_ST71 || req_op == OP_RESET;
	// Copy sequences are not offered, so page pairing never arises
	wire       op_ok    = (req_op <= OP_RESET)
		&& (req_op != OP_ERASE2 || (dist_ok && half_ok));
	wire       accept   = cmd_wr && state_q == S_IDLE && busy_ok && op_ok;
	wire [ROW_W-1:0] row_a = {6'h00, blk_a_q, 6'h00};
	wire [ROW_W-1:0] row_b = {6'h00, blk_b_q, 6'h00};
	wire [10:0] stp    = step_f(op_q, idx_q, row_a, row_b);
	wire [2:0]  kind   = stp[10:8];
	wire        is_era = op_q == OP_ERASE1 || op_q == OP_ERASE2;
	// Software register writes
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			blk_a_q     <= '0;
			blk_b_q     <= '0;
			wp_permit_q <= WP_PERMIT_RST;
			refused_q   <= 1'b0;
		end else if (clk_en_i) begin
			if (wr_i && addr_i == REG_BLK_A)
				blk_a_q <= wdata_i[BLK_W-1:0];
			if (wr_i && addr_i == REG_BLK_B)
				blk_b_q <= wdata_i[BLK_W-1:0];
			if (wr_i && addr_i == REG_CTRL)
				wp_permit_q <= wdata_i[0];
			if (cmd_wr)
				refused_q <= !accept;
		end
	end
	// Pin sequencer
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q    <= S_IDLE;
			op_q       <= OP_ST70;
			idx_q      <= 4'h0;
			cnt_q      <= 4'h0;
			rd_cnt_q   <= 3'h0;
			pf_valid_q <= 1'b0;
			status_q   <= 8'h00;
			io_o       <= 8'h00;
			io_oe_o    <= 1'b0;
			cle_o      <= 1'b0;
			ale_o      <= 1'b0;
			ce_n_o     <= 1'b1;
			we_n_o     <= 1'b1;
			read_strobe_n_o <= 1'b1;
			for (int k = 0; k < ID_BYTES; k++)
				id_q[k] <= 8'h00;
		end else if (clk_en_i) begin
			case (state_q)
				S_IDLE: begin
					if (accept) begin
						op_q       <= req_op;
						idx_q      <= 4'h0;
						rd_cnt_q   <= 3'h0;
						pf_valid_q <= 1'b0;
						ce_n_o     <= 1'b0;
						state_q    <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (kind == K_CMD || kind == K_ADDR) begin
						io_o    <= stp[7:0];
						io_oe_o <= 1'b1;
						cle_o   <= kind == K_CMD;
						ale_o   <= kind == K_ADDR;
						we_n_o  <= 1'b0;
						cnt_q   <= WP_CYC - 4'h1;
						state_q <= S_WLO;
					end else if (kind == K_READ) begin
						read_strobe_n_o <= 1'b0;
						cnt_q   <= RD_LO_CYC - 4'h1;
						state_q <= S_RLO;
					end else if (kind == K_WAIT) begin
						cnt_q   <= WB_CYC - 4'h1;
						state_q <= S_WB;
					end else begin
						ce_n_o     <= 1'b1;
						pf_valid_q <= is_era;
						state_q    <= S_IDLE;
					end
				end
				S_WLO: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						we_n_o  <= 1'b1;
						cnt_q   <= WH_CYC - 4'h1;
						state_q <= S_WHI;
					end
				end
				S_WHI: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						cle_o   <= 1'b0;
						ale_o   <= 1'b0;
						io_oe_o <= 1'b0;
						idx_q   <= idx_q + 4'h1;
						state_q <= S_FETCH;
					end
				end
				S_RLO: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						if (op_q == OP_ID)
							id_q[rd_cnt_q] <= io_s2_q;
						else
							status_q <= io_s2_q;
						rd_cnt_q <= rd_cnt_q + 3'h1;
						read_strobe_n_o <= 1'b1;
						cnt_q   <= WH_CYC - 4'h1;
						state_q <= S_RHI;
					end
				end
				S_RHI: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						idx_q   <= idx_q + 4'h1;
						state_q <= S_FETCH;
					end
				end
				S_WB: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0)
						state_q <= S_WRDY;
				end
				S_WRDY: begin
					if (rb_s2_q) begin
						idx_q   <= idx_q + 4'h1;
						state_q <= S_FETCH;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
	// Register read mux
	wire        busy   = state_q != S_IDLE;
	wire [31:0] st_w   = {15'h0000, rb_s2_q, status_q,
		5'h00, pf_valid_q, refused_q, busy};
	wire [31:0] rd_mux =
		(addr_i == REG_STATUS) ? st_w :
		(addr_i == REG_ID_LO) ? {id_q[3], id_q[2], id_q[1], id_q[0]} :
		(addr_i == REG_ID_HI) ? {24'h000000, id_q[4]} :
		(addr_i == REG_BLK_A) ? {20'h00000, blk_a_q} :
		(addr_i == REG_BLK_B) ? {20'h00000, blk_b_q} :
		(addr_i == REG_CTRL) ? {31'h00000000, wp_permit_q} :
		(addr_i == REG_CMD) ? {29'h00000000, op_q} : 32'h00000000;
	// Read data and write-protect pin
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_o <= 32'h00000000;
			wp_n_o  <= 1'b0;
		end else if (clk_en_i) begin
			rdata_o <= rd_i ? rd_mux : 32'h00000000;
			wp_n_o  <= wp_permit_q;
		end
	end
endmodule
`default_nettype wire

// ===== verification/nfh_host_monitor.sv
// Checker of host pin and register port timing
`default_nettype none
module nfh_host_monitor
	import nfh_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [7:0]  io_o,
	input wire logic        io_oe_o,
	input wire logic        cle_o,
	input wire logic        ale_o,
	input wire logic        ce_n_o,
	input wire logic        we_n_o,
	input wire logic        read_strobe_n_o,
	input wire logic        wp_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Pin sequencing and register port timing
	a_write_hold: assert property ($fell(we_n_o) |=> we_n_o
		&& io_oe_o && $stable(io_o) && $stable(cle_o))
		else $error("write byte not held");
	a_byte_kind: assert property ($rose(we_n_o) |-> cle_o ^ ale_o)
		else $error("write byte neither command nor address");
	a_drive_start: assert property ($rose(io_oe_o) |->
		!we_n_o && (cle_o || ale_o))
		else $error("bus driven without strobe");
	a_read_low: assert property ($fell(read_strobe_n_o) |->
		!read_strobe_n_o [*3] ##1 read_strobe_n_o)
		else $error("read strobe length wrong");
	a_read_quiet: assert property (!read_strobe_n_o |->
		!io_oe_o && !cle_o && !ale_o && !ce_n_o)
		else $error("bus contention during read");
	a_strobe_sel: assert property (!we_n_o |-> !ce_n_o)
		else $error("write strobe while deselected");
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside its cycle");
	a_wp_follow: assert property (wr_i && addr_i == REG_CTRL |->
		##2 wp_n_o == $past(wdata_i[0], 2))
		else $error("protect pin not following control");
endmodule
bind nfh_host nfh_host_monitor mon_u (.clk_i, .sys_rst_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .io_o, .io_oe_o, .cle_o, .ale_o,
	.ce_n_o, .we_n_o, .read_strobe_n_o, .wp_n_o);
`default_nettype wire

// ===== verification/nfh_dev_model.sv
// Behavioural NAND device for erase, ID and status commands
`default_nettype none
module nfh_dev_model #(
	parameter logic [7:0]  MAK_ID   = 8'h5A, // Arbitrary value
	parameter logic [7:0]  DEV_ID   = 8'hA5, // Arbitrary value
	parameter logic [11:0] FAIL_BLK = 12'h007,
	parameter int          BUSY     = 30
) (
	input  wire logic       clk_i,
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic       ce_n_i,
	input  wire logic       we_n_i,
	input  wire logic       re_n_i,
	input  wire logic       wp_n_i,
	input  wire logic [7:0] io_i,
	output logic      [7:0] io_o,
	output logic            rb_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  cmd = 8'h00, last = 8'h00;
	logic [23:0] row = 24'h0;
	logic [1:0]  pf = 2'b00, fl = 2'b00;
	int          idx = 0, na = 0;
	// Identification bytes in readout order
	logic [7:0]  id [5] = '{MAK_ID, DEV_ID,
		{4'b1001, 2'b00, 2'b01},
		{2'b00, 2'b10, 2'b01, 2'b10},
		{4'b0111, 2'b01, 2'b10}};
	// Status bytes for the two status commands
	wire logic [7:0] st70 = {wp_n_i, rb_o, rb_o, 4'h0, |fl};
	wire logic [7:0] st71 = {wp_n_i, rb_o, rb_o, 2'b00, fl, |fl};
	initial begin
		io_o = 8'h00;
		rb_o = 1'b1;
	end
	// Latch on write strobe rise; erase busy after start
	always @(posedge we_n_i)
		if (!ce_n_i && ale_i) begin
			row = {io_i, row[23:8]};
			na = na + 1;
			if (na % 3 == 0 && row[17:6] == FAIL_BLK)
				pf[row[6]] = 1'b1;
		end else if (!ce_n_i && cle_i) begin
			cmd = io_i;
			na = 0;
			idx = 0;
			if (io_i == 8'hD0 || io_i == 8'hFF) begin
				if (io_i == 8'hD0)
					fl = pf;
				pf = 2'b00;
				rb_o = 1'b0;
				repeat (BUSY) @(posedge clk_i);
				rb_o = 1'b1;
			end
		end
	// Byte out while read strobe is low, inverted once released
	always @(negedge re_n_i)
		if (!ce_n_i) begin
			last = cmd == 8'h90 ? id[idx] : cmd == 8'h71 ? st71 : st70;
			io_o = last;
			idx = idx + 1;
		end
	always @(posedge re_n_i)
		io_o = ~last;
endmodule
`default_nettype wire

// ===== verification/nfh_host_tb_top.sv
// Testbench for the NAND host controller
`default_nettype none
module nfh_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import nfh_pkg::*;
	localparam logic [7:0] MAK_ID = 8'h5A; // Arbitrary value
	localparam logic [7:0] DEV_ID = 8'hA5; // Arbitrary value
	logic        clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1;
	logic        wr_i = 1'b0, rd_i = 1'b0;
	logic [7:0]  addr_i = 8'h00, h_io, d_io, bus;
	logic [31:0] wdata_i = 32'h0, rdata_o, st;
	logic        oe, cle, ale, ce_n, we_n, re_n, wp_n, rb;
	int          mismatches = 0, checked = 0;
	assign bus = oe ? h_io : d_io; // Level on the shared bus
	always #20 clk_i = ~clk_i;
	nfh_host dut_u (.clk_i, .sys_rst_i, .clk_en_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .io_i(bus), .io_o(h_io), .io_oe_o(oe),
		.cle_o(cle), .ale_o(ale), .ce_n_o(ce_n), .we_n_o(we_n),
		.read_strobe_n_o(re_n), .wp_n_o(wp_n), .ready_n_busy_i(rb));
	nfh_dev_model #(.MAK_ID(MAK_ID), .DEV_ID(DEV_ID)) dev_u (.clk_i,
		.cle_i(cle), .ale_i(ale), .ce_n_i(ce_n), .we_n_i(we_n),
		.re_n_i(re_n), .wp_n_i(wp_n), .io_i(bus), .io_o(d_io), .rb_o(rb));
	// Register port cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 st = rdata_o;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	// Poll until idle; running out of polls counts as a mismatch
	task automatic idle;
		int n = 0;
		do rd(REG_STATUS); while (st[0] !== 1'b0 && ++n < 500);
		chk("idle", 32'h0, {31'h0, st[0]});
	endtask
	// Start an operation and wait for it to finish
	task automatic run(input logic [2:0] op);
		wr(REG_CMD, {28'h0, 1'b1, op});
		idle;
	endtask
	task automatic t_reset;
		rd(REG_STATUS);
		chk("status", 32'h0, st & 32'hFF07);
		rd(8'h40);
		chk("unmapped", 32'h0, st);
		chk("wp pin", 32'h0, {31'h0, wp_n});
		$display("reset test done");
	endtask
	task automatic t_erase;
		wr(REG_CTRL, 32'h1);
		wr(REG_BLK_A, 32'h805);
		run(OP_ERASE1);
		chk("erase status", 32'hE004, st & 32'hFF07);
		wr(REG_BLK_A, 32'h7);
		wr(REG_BLK_B, 32'h2);
		run(OP_ERASE2);
		chk("dual status", 32'hE504, st & 32'hFF07);
		$display("erase test done");
	endtask
	task automatic t_refuse;
		logic [31:0] b [2] = '{32'h9, 32'h802};
		foreach (b[i]) begin
			wr(REG_BLK_B, b[i]);
			wr(REG_CMD, {28'h0, 1'b1, OP_ERASE2});
			rd(REG_STATUS);
			chk("refused", 32'h2, st & 32'h3);
		end
		// A second command while the sequencer works is refused
		wr(REG_CMD, {28'h0, 1'b1, OP_RESET});
		wr(REG_CMD, {28'h0, 1'b1, OP_ID});
		rd(REG_STATUS);
		chk("busy refused", 32'h3, st & 32'h3);
		idle;
		$display("refuse test done");
	endtask
	task automatic t_ident;
		run(OP_ID);
		rd(REG_ID_LO);
		chk("id low", {8'h26, 8'h91, DEV_ID, MAK_ID}, st);
		rd(REG_ID_HI);
		chk("id high", 32'h76, st);
		$display("ident test done");
	endtask
	task automatic t_status;
		wr(REG_CTRL, 32'h0);
		run(OP_ST70);
		chk("status byte", 32'h6100, st & 32'hFF00);
		chk("wp pin", 32'h0, {31'h0, wp_n});
		run(OP_ST71);
		chk("district byte", 32'h6500, st & 32'hFF00);
		run(OP_RESET);
		chk("reset op", 32'h0, st & 32'h3);
		$display("status test done");
	endtask
	task automatic print_verdict;
		$display("checked %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_reset;
		t_erase;
		t_refuse;
		t_ident;
		t_status;
		print_verdict;
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		print_verdict;
	end
endmodule
`default_nettype wire
